/* rtl/amp_fault_protect_regs.vh */
`ifndef AMP_FAULT_PROTECT_REGS_VH
`define AMP_FAULT_PROTECT_REGS_VH

// Clock rate in MHz
`define CLK_MHZ 200
// Least spacing between the fault flag falling and a reset rise, in us
`define OVERLOAD_HOLD_US 4000
// Length of one short check step, in us
`define SHORT_STEP_US 10
// Start-up settle time after reset rise, in us
`define STARTUP_US 1

// Output configuration codes
`define MODE_BTL 2'h0
`define MODE_PARALLEL_BRIDGE_MODE 2'h1
`define MODE_SE 2'h2

// Half-bridge group masks
`define HB_AB 4'h3
`define HB_CD 4'hC
`define HB_ALL 4'hF
`define HB_NONE 4'h0

`endif

/* rtl/level_sync.v */
`timescale 1ns/10ps
`default_nettype none

// Two-stage synchroniser for a bundle of asynchronous levels
module level_sync #(
    parameter WIDTH = 1
) (
    input wire core_clk,
    input wire rst,
    input wire [WIDTH-1:0] async_in,
    output reg [WIDTH-1:0] sync_out
);

    reg [WIDTH-1:0] stage1;

    always @(posedge core_clk) begin
        if (rst) begin
            stage1 <= {WIDTH{1'b0}};
            sync_out <= {WIDTH{1'b0}};
        end else begin
            stage1 <= async_in;
            sync_out <= stage1;
        end
    end

endmodule // level_sync

`default_nettype wire

/* rtl/amp_fault_protect_report.v */
// Overview of operation
// - Fault and warning flags only pull low
// - Any shutdown fault pulls fault flag low
// - Warnings low above 125 and 100 degrees
// - Three flags encode fault, warning, normal state
// - Reset low forces fault flag high
// - Fault tristates affected outputs, flag low
// - Non-latched faults recover automatically
// - Mode maps local error to bridge group
// - Bootstrap undervoltage stops only its half-bridge
// - Short check only once after power-up
// - Check ground then supply; hold tristate
// - During check flag low, reset ignored
// - Pass releases flag; never rerun
// - Short check skipped in single-ended mode
// - Large package: 100 warn, 155 warn+shutdown
// - Small package: 125 warn, 155 shutdown
// - Overtemperature latched until reset asserted
// - Supply undervoltage tristates all, auto recovers
// - Reset low: tristate, pulldown unless single-ended
// - Reset rise clears overload; 4 ms spacing
// - Reset rise runs start-up then switching
// - Ready low on overcurrent event
`timescale 1ns/10ps
`default_nettype none
`include "amp_fault_protect_regs.vh"

module amp_fault_protect_report #(
    parameter LARGE_PACKAGE = 1,
    parameter HOLD_CYCLES = `OVERLOAD_HOLD_US * `CLK_MHZ,
    parameter STEP_CYCLES = `SHORT_STEP_US * `CLK_MHZ,
    parameter STARTUP_CYCLES = `STARTUP_US * `CLK_MHZ
) (
    input wire core_clk,
    input wire rst,
    input wire [1:0] output_mode,
    input wire reset_n,
    input wire over_100c,
    input wire over_125c,
    input wire over_155c,
    input wire [3:0] overload_protect,
    input wire [3:0] overcurrent_protect,
    input wire [3:0] gate_drive_supply_low,
    input wire logic_supply_low,
    input wire [3:0] bootstrap_low,
    input wire short_to_ground,
    input wire short_to_power_stage_supply,
    output reg short_test_ground,
    output reg short_test_supply,
    output reg [3:0] hb_hiz,
    output reg [3:0] hb_weak_pulldown,
    output reg fault_shutdown_n_out,
    output reg fault_shutdown_n_oe,
    output reg temp_warning_n_out,
    output reg temp_warning_n_oe,
    output reg temp_warning_low_n_out,
    output reg temp_warning_low_n_oe,
    output reg temp_warning_high_n_out,
    output reg temp_warning_high_n_oe,
    output reg ready,
    output reg switching
);

    localparam ST_CHK_GND = 3'h0;
    localparam ST_CHK_SUP = 3'h1;
    localparam ST_RESET = 3'h2;
    localparam ST_START = 3'h3;
    localparam ST_RUN = 3'h4;

    // Map a set of local errors onto the half-bridges to turn off
    function [3:0] group_of;
        input [3:0] err;
        input [1:0] mode;
        begin
            case (mode)
                `MODE_PARALLEL_BRIDGE_MODE: begin
                    // Paralleled bridges share the load, so all go off
                    group_of = (|err) ? `HB_ALL : `HB_NONE;
                end
                `MODE_BTL, `MODE_SE: begin
                    group_of = ((|err[1:0]) ? `HB_AB : `HB_NONE)
                             | ((|err[3:2]) ? `HB_CD : `HB_NONE);
                end
                default: begin
                    group_of = ((|err[1:0]) ? `HB_AB : `HB_NONE)
                             | ((|err[3:2]) ? `HB_CD : `HB_NONE);
                end
            endcase
        end
    endfunction

    wire reset_sync;
    wire [2:0] temp_sync;
    wire [15:0] bridge_sync;
    wire [2:0] misc_sync;

    // Device reset pin, kept apart from the comparators
    level_sync #(.WIDTH(1)) reset_sync_inst (
        .core_clk(core_clk),
        .rst(rst),
        .async_in(reset_n),
        .sync_out(reset_sync)
    );

    // Temperature comparators
    level_sync #(.WIDTH(3)) temp_sync_inst (
        .core_clk(core_clk),
        .rst(rst),
        .async_in({over_100c, over_125c, over_155c}),
        .sync_out(temp_sync)
    );

    // Per half-bridge detections
    level_sync #(.WIDTH(16)) bridge_sync_inst (
        .core_clk(core_clk),
        .rst(rst),
        .async_in({overload_protect, overcurrent_protect, gate_drive_supply_low, bootstrap_low}),
        .sync_out(bridge_sync)
    );

    // Logic supply and start-up short detectors
    level_sync #(.WIDTH(3)) misc_sync_inst (
        .core_clk(core_clk),
        .rst(rst),
        .async_in({logic_supply_low, short_to_ground, short_to_power_stage_supply}),
        .sync_out(misc_sync)
    );

    wire s_reset_n = reset_sync;
    wire s_100 = temp_sync[2];
    wire s_125 = temp_sync[1];
    wire s_155 = temp_sync[0];
    wire [3:0] s_ol = bridge_sync[15:12];
    wire [3:0] s_oc = bridge_sync[11:8];
    wire [3:0] s_gvdd = bridge_sync[7:4];
    wire [3:0] s_bst = bridge_sync[3:0];
    wire s_vdd = misc_sync[2];
    wire s_sgnd = misc_sync[1];
    wire s_ssup = misc_sync[0];

    reg [2:0] state;
    reg [2:0] next_state;
    reg [31:0] count;
    reg reset_n_d;
    reg overtemp_error;
    reg [3:0] overload_latch;
    reg check_done;

    wire reset_rise = s_reset_n & ~reset_n_d;
    wire under_voltage = s_vdd | (|s_gvdd);
    // A finished check never counts as in_check again, even under a stray state code
    wire in_check = !check_done && ((state == ST_CHK_GND) || (state == ST_CHK_SUP));
    wire step_done = (count >= STEP_CYCLES - 1);
    wire start_done = (count >= STARTUP_CYCLES - 1);

    // Overtemp cleared by reset low, overload by reset rise, neither during the check
    always @(posedge core_clk) begin
        if (rst) begin
            reset_n_d <= 1'b0;
            overtemp_error <= 1'b0;
            overload_latch <= 4'h0;
        end else begin
            reset_n_d <= s_reset_n;
            if (s_155)
                overtemp_error <= 1'b1;
            else if (!s_reset_n && !in_check)
                overtemp_error <= 1'b0;
            if (|s_ol)
                overload_latch <= overload_latch | s_ol;
            else if (reset_rise && !in_check)
                overload_latch <= 4'h0;
        end
    end

    always @* begin
        next_state = state;
        case (state)
            ST_CHK_GND: begin
                if (output_mode == `MODE_SE)
                    next_state = ST_RESET;
                else if (step_done && !s_sgnd)
                    next_state = ST_CHK_SUP;
            end
            ST_CHK_SUP: begin
                if (step_done && !s_ssup)
                    next_state = ST_RESET;
            end
            ST_RESET: begin
                if (s_reset_n)
                    next_state = ST_START;
            end
            ST_START: begin
                if (!s_reset_n)
                    next_state = ST_RESET;
                else if (start_done)
                    next_state = ST_RUN;
            end
            ST_RUN: begin
                if (!s_reset_n)
                    next_state = ST_RESET;
            end
            default: next_state = ST_RESET;
        endcase
    end

    // Check only from power-on reset; later resets land in ST_RESET
    always @(posedge core_clk) begin
        if (rst) begin
            state <= ST_CHK_GND;
            count <= 32'h0000_0000;
            check_done <= 1'b0;
        end else begin
            state <= next_state;
            if (next_state != state)
                count <= 32'h0000_0000;
            else if ((state == ST_CHK_GND && s_sgnd) || (state == ST_CHK_SUP && s_ssup))
                count <= 32'h0000_0000; // Short persists, restart the step
            else if (count != 32'hFFFF_FFFF)
                count <= count + 32'h0000_0001;
            if (next_state == ST_RESET && in_check)
                check_done <= 1'b1;
        end
    end

    reg [3:0] next_hiz;
    reg [3:0] next_pd;
    reg next_fault;

    // Any condition that keeps the stage off while running
    wire run_fault = overtemp_error || under_voltage || (|overload_latch)
                   || (|s_oc) || (|s_bst);

    always @* begin
        next_hiz = `HB_ALL;
        next_pd = `HB_NONE;
        next_fault = 1'b0;
        case (state)
            ST_CHK_GND, ST_CHK_SUP: begin
                next_hiz = `HB_ALL;
                next_fault = 1'b1;
            end
            ST_RESET: begin
                next_hiz = `HB_ALL;
                if (output_mode != `MODE_SE)
                    next_pd = `HB_ALL;
                next_fault = 1'b0;
            end
            ST_START: begin
                // Stay off until the settle time has run out
                next_hiz = `HB_ALL;
                next_fault = run_fault;
            end
            ST_RUN: begin
                next_hiz = group_of(overload_latch | s_oc, output_mode)
                         | s_bst;
                if (overtemp_error || under_voltage)
                    next_hiz = `HB_ALL;
                next_fault = run_fault;
            end
            default: begin
                // Unknown state: fail safe with the stage off
                next_hiz = `HB_ALL;
                next_fault = 1'b1;
            end
        endcase
    end

    // Warning pins: single always on 125; large package adds low and high, small drives high from 125 too
    wire warn_low = LARGE_PACKAGE ? s_100 : 1'b0;
    wire warn_high = LARGE_PACKAGE ? s_155 : 1'b0;
    wire warn_single = s_125;

    always @(posedge core_clk) begin
        if (rst) begin
            hb_hiz <= `HB_ALL;
            hb_weak_pulldown <= `HB_NONE;
            fault_shutdown_n_out <= 1'b0;
            fault_shutdown_n_oe <= 1'b0;
            temp_warning_n_out <= 1'b0;
            temp_warning_n_oe <= 1'b0;
            temp_warning_low_n_out <= 1'b0;
            temp_warning_low_n_oe <= 1'b0;
            temp_warning_high_n_out <= 1'b0;
            temp_warning_high_n_oe <= 1'b0;
            ready <= 1'b0;
            switching <= 1'b0;
            short_test_ground <= 1'b0;
            short_test_supply <= 1'b0;
        end else begin
            hb_hiz <= next_hiz;
            hb_weak_pulldown <= next_pd;
            // Open-drain: data always low, enable pulls
            fault_shutdown_n_oe <= next_fault;
            temp_warning_n_oe <= warn_single;
            temp_warning_low_n_oe <= warn_low;
            temp_warning_high_n_oe <= LARGE_PACKAGE ? warn_high : s_125;
            ready <= (state == ST_RUN) && !(|s_oc) && !next_fault;
            switching <= (state == ST_RUN) && (next_hiz != `HB_ALL);
            short_test_ground <= (state == ST_CHK_GND) && (output_mode != `MODE_SE);
            short_test_supply <= (state == ST_CHK_SUP);
        end
    end

endmodule // amp_fault_protect_report

`default_nettype wire

/* bench/flag_pullup_model.sv */
`timescale 1ns/10ps
`default_nettype none
module flag_pullup_model #(
    parameter HOLD_CYCLES = 50
) (
    input wire logic core_clk,
    input wire logic [3:0] pin_out,
    input wire logic [3:0] pin_oe,
    output logic [3:0] pin_level,
    output logic hold_done
);
    integer cnt = 0;
    logic last = 1'b1;
    // Open-drain wires float to the pull-up level
    assign pin_level = (pin_oe & pin_out) | ~pin_oe;
    // Controller may not release reset too soon after the fault flag fell
    assign hold_done = (cnt >= HOLD_CYCLES);
    always @(posedge core_clk) begin
        if (last && !pin_level[0]) cnt <= 0;
        else if (cnt < HOLD_CYCLES) cnt <= cnt + 1;
        last <= pin_level[0];
    end
endmodule // flag_pullup_model
`default_nettype wire

/* bench/amp_fault_protect_assertions.sv */
`timescale 1ns/10ps
`default_nettype none
module amp_fault_protect_checker (
    input wire core_clk,
    input wire rst,
    input wire reset_n,
    input wire logic_supply_low,
    input wire over_100c,
    input wire over_125c,
    input wire [3:0] overcurrent_protect,
    input wire short_test_ground,
    input wire short_test_supply,
    input wire [3:0] hb_hiz,
    input wire fault_shutdown_n_out,
    input wire fault_shutdown_n_oe,
    input wire temp_warning_n_oe,
    input wire temp_warning_low_n_oe,
    input wire ready
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);
    sequence check_run;
        short_test_ground || short_test_supply;
    endsequence
    sequence reset_held;
        (!reset_n && !short_test_ground && !short_test_supply)[*5];
    endsequence
    a_flag_only_low: assert property (!fault_shutdown_n_out) else $error("flag driven high");
    a_check_holds_flag: assert property (check_run |-> fault_shutdown_n_oe && hb_hiz == 4'hF)
        else $error("check without flag or tristate");
    a_ground_then_supply: assert property ($rose(short_test_supply) |-> $past(short_test_ground))
        else $error("supply step before ground step");
    a_reset_forces_high: assert property (reset_held |-> !fault_shutdown_n_oe && hb_hiz == 4'hF)
        else $error("reset low not honoured");
    a_uv_tristates_all: assert property ((logic_supply_low && reset_n)[*6] |->
        fault_shutdown_n_oe && hb_hiz == 4'hF) else $error("undervoltage not handled");
    a_hot_warning: assert property (over_125c[*5] |-> temp_warning_n_oe)
        else $error("hot warning missing");
    a_warm_warning: assert property (over_100c[*5] |-> temp_warning_low_n_oe)
        else $error("warm warning missing");
    a_ready_drops: assert property ((|overcurrent_protect)[*5] |-> !ready)
        else $error("ready high on overcurrent");
endmodule // amp_fault_protect_checker
bind amp_fault_protect_report amp_fault_protect_checker amp_fault_protect_checker_inst (
    .core_clk, .rst, .reset_n, .logic_supply_low, .over_100c, .over_125c, .overcurrent_protect,
    .short_test_ground, .short_test_supply, .hb_hiz, .fault_shutdown_n_out, .fault_shutdown_n_oe,
    .temp_warning_n_oe, .temp_warning_low_n_oe, .ready);
`default_nettype wire

/* bench/amp_fault_protect_report_tb.sv */
`timescale 1ns/10ps
`default_nettype none
module amp_fault_protect_report_tb;
    logic core_clk = 0, rst = 1, rn = 0, t1 = 0, t2 = 0, t3 = 0, ls = 0, sg = 0, ss = 0;
    logic [1:0] mode = 2'h0;
    logic [3:0] ol = 4'h0, oc = 4'h0, gd = 4'h0, bs = 4'h0;
    wire stg, sts, rdy, hd, sw;
    wire [3:0] hiz, pd, po, pe, pin;
    integer err_total = 0, checked = 0, i;
    always #2.5 core_clk = ~core_clk;
    amp_fault_protect_report #(.STEP_CYCLES(4), .STARTUP_CYCLES(2)) amp_fault_protect_report_inst (
        .core_clk(core_clk), .rst(rst), .output_mode(mode), .reset_n(rn), .over_100c(t1),
        .over_125c(t2), .over_155c(t3), .overload_protect(ol), .overcurrent_protect(oc),
        .gate_drive_supply_low(gd), .logic_supply_low(ls), .bootstrap_low(bs),
        .short_to_ground(sg), .short_to_power_stage_supply(ss), .short_test_ground(stg),
        .short_test_supply(sts), .hb_hiz(hiz), .hb_weak_pulldown(pd),
        .fault_shutdown_n_out(po[0]), .fault_shutdown_n_oe(pe[0]),
        .temp_warning_n_out(po[1]), .temp_warning_n_oe(pe[1]),
        .temp_warning_low_n_out(po[2]), .temp_warning_low_n_oe(pe[2]),
        .temp_warning_high_n_out(po[3]), .temp_warning_high_n_oe(pe[3]),
        .ready(rdy), .switching(sw));
    flag_pullup_model flag_pullup_model_inst (.core_clk(core_clk), .pin_out(po), .pin_oe(pe),
        .pin_level(pin), .hold_done(hd));
    task wrap_up;
        if (err_total == 0 && checked > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task chk(input logic [7:0] got, input logic [7:0] exp);
        checked = checked + 1;
        if (got !== exp) begin
            err_total = err_total + 1;
            $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task tick(input integer n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask
    // Bounded wait; a hang ends the run
    task await_ready;
        integer k;
        for (k = 0; k < 200 && rdy !== 1'b1; k++) tick(1);
        if (rdy !== 1'b1) begin
            err_total = err_total + 1;
            $display("CHECK FAILED t=%0t ready timeout", $time);
            wrap_up;
        end
    endtask
    initial begin
        tick(6);
        rst = 0;
        sg = 1;
        ss = 1;
        rn = 1;
        tick(10);
        rn = 0;
        tick(10);
        chk({stg, pe[0], hiz}, 8'h3F);
        sg = 0;
        tick(20);
        chk({stg, sts, pe[0], hiz}, 8'h3F);
        rn = 1;
        ss = 0;
        await_ready;
        chk({pin, hiz}, 8'hF0);
        chk(sw, 8'h01);
        for (i = 0; i < 4; i++) begin
            oc = 4'h1 << i;
            tick(6);
            chk({rdy, hiz}, (i < 2) ? 8'h03 : 8'h0C);
            oc = 4'h0;
            tick(6);
            chk({rdy, hiz}, 8'h10);
        end
        bs = 4'h4;
        tick(6);
        chk(hiz, 8'h04);
        bs = 4'h0;
        gd = 4'h2;
        tick(6);
        chk({pin[0], hiz}, 8'h0F);
        gd = 4'h0;
        tick(8);
        chk({pin[0], hiz}, 8'h10);
        ls = 1;
        tick(8);
        chk({pin[0], hiz, sw}, 8'h1E);
        ls = 0;
        tick(8);
        chk({pin[0], hiz, sw}, 8'h21);
        t1 = 1;
        tick(6);
        chk(pin, 8'h0B);
        t2 = 1;
        tick(6);
        chk(pin, 8'h09);
        t3 = 1;
        tick(6);
        chk({pin, hiz}, 8'h0F);
        {t1, t2, t3} = 3'h0;
        tick(6);
        chk({pin, hiz}, 8'hEF);
        rn = 0;
        tick(6);
        chk({pin, pd}, 8'hFF);
        rn = 1;
        await_ready;
        chk({stg, hiz}, 8'h00);
        ol = 4'h8;
        tick(6);
        chk({pin[0], hiz}, 8'h0C);
        ol = 4'h0;
        tick(6);
        chk(pin[0], 8'h00);
        for (i = 0; i < 100 && hd !== 1'b1; i++) tick(1);
        if (hd !== 1'b1) begin
            err_total = err_total + 1;
            $display("CHECK FAILED t=%0t hold timeout", $time);
            wrap_up;
        end
        rn = 0;
        tick(6);
        rn = 1;
        await_ready;
        chk({pin[0], hiz}, 8'h10);
        rst = 1;
        mode = 2'h1;
        tick(6);
        rst = 0;
        await_ready;
        oc = 4'h4;
        tick(6);
        chk(hiz, 8'h0F);
        oc = 4'h0;
        rst = 1;
        mode = 2'h2;
        tick(6);
        rst = 0;
        tick(3);
        chk({stg, sts}, 8'h00);
        await_ready;
        wrap_up;
    end
endmodule // amp_fault_protect_report_tb
`default_nettype wire
